/* src/spi_command_crc_frontend.sv */
// Serial command interpreter with optional command and response checksum
`timescale 1ns/1ps
`include "spi_frontend_regs.svh"

// Notes on behaviour
// RULE1: With status append set, status byte precedes data; status also readable.
// RULE2: Conversion word is 24-bit two's complement, sign bit shifted first.
// RULE3: Overdrive clips to positive or negative full scale, never wraps.
// RULE4: Zero input gives the all-zero code, negatives below in two's complement.
// RULE5: Checksum check and output only while the checksum enable bit is set.
// RULE6: Host sends checksum of both command bytes third, then a zero byte.
// RULE7: On match, execute and send the recomputed checksum during byte four.
// RULE8: Reads in checksum mode append a checksum over the 1, 3 or 4 payload bytes.
// RULE9: On mismatch, do not execute; send inverted checksum of received bytes.
// RULE10: A command checksum mismatch sets the failure flag in status.
// RULE11: After a failed frame, a new command starts right after byte four.
// RULE12: Checksum is 8-bit remainder, polynomial x8+x2+x+1, preset all ones.
// RULE13: Data checksum over three data bytes, or status plus data; register over one.
// RULE14: Echo byte one during byte two; in checksum mode echo byte two in three.
// RULE15: Execute after byte two without checksum, after byte four with it.
// RULE16: Byte two is write data for register writes, else ignored but checksummed.
// RULE17: Chip select high aborts the frame; falling select restarts byte counting.
// RULE18: Register read is base plus 5-bit address; write likewise, data in byte two.
// RULE19: Host sends only the defined opcodes.
// RULE20: No-operation has no effect beyond checksum check and response.
// RULE21: Reset opcode restarts operation and returns registers to defaults.
// RULE22: Start opcode begins conversions, stop opcode halts them.
// RULE23: Mode 1 link: clock idles low, out on rising, in on falling edges.
// RULE24: All ones are driven while the first command byte is received; after a failed check or a response in one select, the pin shows ready_n_in.
// RULE25: Same MSB-first checksum order for checking and for generating.
module spi_command_crc_frontend
    import spi_frontend_pkg::*;
#(
    parameter int RAW_W     = 26,
    parameter int REG_COUNT = 32
)
(
    input  wire logic                    mclk_in,
    input  wire logic                    reset_in,
    input  wire logic                    sclk_in,
    input  wire logic                    cs_n_in,
    input  wire logic                    sdi_in,
    output wire logic                    serial_out_ready_pin_out,
    output wire logic                    serial_out_ready_pin_oe_n_out,
    input  wire logic signed [RAW_W-1:0] conv_raw_in,
    input  wire logic                    conv_valid_in,
    input  wire spi_frontend_pkg::byte_t status_in,
    input  wire logic                    ready_n_in,
    output logic                         conv_run_out,
    output logic                         start_pulse_out,
    output logic                         stop_pulse_out,
    output logic                         reset_pulse_out,
    output logic                         system_offset_cal_cmd_out,
    output logic                         gain_cal_cmd_out,
    output logic                         self_offset_cal_cmd_out,
    output logic                         crc_fail_flag_out,
    output logic                         locked_out,
    output spi_frontend_pkg::byte_t      mode_config_three_out
);
    import spi_frontend_pkg::*;

    // ------------------------------------------------------------------
    // Checksum step, MSB first
    // ------------------------------------------------------------------
    function automatic byte_t crc8(input byte_t crc, input byte_t data);
        byte_t c;
        c = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (c[7] ^ data[i])
                c = {c[6:0], 1'b0} ^ `CRC_POLY; // RULE12 RULE25
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic        link_rst;
    logic        cs_meta;
    logic        cs_sync;
    logic        exec_meta;
    logic        exec_sync;
    logic        exec_seen;
    logic        fail_meta;
    logic        fail_sync;
    logic        fail_seen;
    byte_t       reg_file [REG_COUNT];
    logic        crc_flag;
    logic        locked;
    logic [23:0] conv_word;
    logic [23:0] snap_word;
    byte_t       snap_status;

    logic        exec_tgl;
    logic        fail_tgl;
    logic [1:0]  cfg_meta;
    logic [1:0]  cfg_sync;
    logic [2:0]  bit_cnt;
    phase_t      phase;
    byte_t       rx_sh;
    byte_t       cmd1;
    byte_t       cmd2;
    byte_t       cmd_crc;
    byte_t       tx_byte;
    logic [39:0] pay;
    logic [2:0]  pay_left;
    byte_t       pay_crc;
    logic        crc_pend;
    logic        busy;
    logic        sout;

    // ------------------------------------------------------------------
    // Reset into the link domain, select synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        link_rst <= reset_in;
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
        end
        else
        begin
            cs_meta <= cs_n_in;
            cs_sync <= cs_meta;
        end
    end

    // ------------------------------------------------------------------
    // Event crossing from the link, toggle based
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            exec_meta <= 1'b0;
            exec_sync <= 1'b0;
            exec_seen <= 1'b0;
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
            fail_seen <= 1'b0;
        end
        else
        begin
            exec_meta <= exec_tgl;
            exec_sync <= exec_meta;
            exec_seen <= exec_sync;
            fail_meta <= fail_tgl;
            fail_sync <= fail_meta;
            fail_seen <= fail_sync;
        end
    end

    // ------------------------------------------------------------------
    // Command decode, core side
    // ------------------------------------------------------------------
    // Command bytes stay put until the next frame's first byte, long after
    // the toggle has crossed, so reading them here is safe.
    wire       exec_evt  = exec_sync ^ exec_seen;
    wire       fail_evt  = fail_sync ^ fail_seen;
    wire [2:0] op_base   = cmd1[`CMD_BASE_HI:`CMD_BASE_LO];
    wire [4:0] op_addr   = cmd1[`CMD_ADDR_HI:0];
    wire       do_reset  = exec_evt && (cmd1 == `CMD_RESET);
    wire       do_start  = exec_evt && (cmd1 == `CMD_START);
    wire       do_stop   = exec_evt && (cmd1 == `CMD_STOP);
    wire       do_lock   = exec_evt && (cmd1 == `CMD_LOCK);
    wire       do_unlock = exec_evt && (cmd1 == `CMD_UNLOCK);
    wire       do_syo    = exec_evt && (cmd1 == `CMD_SYS_OFFSET_CAL);
    wire       do_gan    = exec_evt && (cmd1 == `CMD_GAIN_CAL);
    wire       do_sfo    = exec_evt && (cmd1 == `CMD_SELF_OFFSET_CAL);
    wire       do_register_write_cmd   = exec_evt && !locked
                           && (op_base == 3'(`CMD_REG_WRITE_BASE >> `CMD_BASE_LO));
    wire       clr_flag  = do_register_write_cmd && (op_addr == `STATUS_ADDR)
                           && !cmd2[`STATUS_CLEAR_BIT];

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    generate
        for (genvar g = 0; g < REG_COUNT; g++)
        begin : g_reg
            always_ff @(posedge mclk_in)
            begin
                if (reset_in || do_reset)
                    reg_file[g] <= `REG_DEFAULT; // RULE21
                else if (do_register_write_cmd && (op_addr == 5'(g)))
                    reg_file[g] <= cmd2; // RULE16 RULE18
            end
        end
    endgenerate

    always_ff @(posedge mclk_in)
    begin
        if (reset_in || do_reset)
            crc_flag <= 1'b0;
        else if (fail_evt)
            crc_flag <= 1'b1; // RULE10
        else if (clr_flag)
            crc_flag <= 1'b0;
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in || do_reset || do_unlock)
            locked <= 1'b0;
        else if (do_lock)
            locked <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (reset_in || do_reset || do_stop)
            conv_run_out <= 1'b0; // RULE22
        else if (do_start)
            conv_run_out <= 1'b1; // RULE22
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            start_pulse_out           <= 1'b0;
            stop_pulse_out            <= 1'b0;
            reset_pulse_out           <= 1'b0;
            system_offset_cal_cmd_out <= 1'b0;
            gain_cal_cmd_out          <= 1'b0;
            self_offset_cal_cmd_out   <= 1'b0;
        end
        else
        begin
            start_pulse_out           <= do_start;
            stop_pulse_out            <= do_stop;
            reset_pulse_out           <= do_reset; // RULE21
            system_offset_cal_cmd_out <= do_syo;
            gain_cal_cmd_out          <= do_gan;
            self_offset_cal_cmd_out   <= do_sfo;
        end
    end

    assign crc_fail_flag_out     = crc_flag;
    assign locked_out            = locked;
    assign mode_config_three_out = reg_file[`MODE_CONFIG_THREE_ADDR];

    // ------------------------------------------------------------------
    // Conversion word, clipped
    // ------------------------------------------------------------------
    wire sat_pos = !conv_raw_in[RAW_W-1] && (|conv_raw_in[RAW_W-2:23]);
    wire sat_neg = conv_raw_in[RAW_W-1] && !(&conv_raw_in[RAW_W-2:23]);
    // Values in range pass unchanged, so zero stays the all-zero code
    wire [23:0] clip_word = sat_pos ? `CODE_POS_FULL :
                            sat_neg ? `CODE_NEG_FULL : conv_raw_in[23:0]; // RULE3 RULE4

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            conv_word <= `CODE_ZERO;
        else if (conv_valid_in)
            conv_word <= clip_word; // RULE2
    end

    wire byte_t status_byte = (status_in & ~(`STATUS_CRCFAIL_MASK | `STATUS_LOCK_MASK))
                              | (crc_flag ? `STATUS_CRCFAIL_MASK : 8'h00)
                              | (locked ? `STATUS_LOCK_MASK : 8'h00);

    // Snapshot frozen while selected, so the link reads a still word
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            snap_word   <= `CODE_ZERO;
            snap_status <= 8'h00;
        end
        else if (cs_sync)
        begin
            snap_word   <= conv_word;
            snap_status <= status_byte; // RULE1
        end
    end

    // ------------------------------------------------------------------
    // Link side: receive, sample on the falling edge
    // ------------------------------------------------------------------
    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            cfg_meta <= 2'b00;
            cfg_sync <= 2'b00;
        end
        else
        begin
            cfg_meta <= {reg_file[`MODE_CONFIG_THREE_ADDR][`MODE_CONFIG_THREE_STAT_BIT],
                         reg_file[`MODE_CONFIG_THREE_ADDR][`MODE_CONFIG_THREE_CRC_BIT]};
            cfg_sync <= cfg_meta;
        end
    end

    wire        crc_en    = cfg_sync[0]; // RULE5
    wire        stat_en   = cfg_sync[1];
    wire        byte_done = (bit_cnt == 3'd7);
    wire byte_t rx_full   = {rx_sh[6:0], sdi_in}; // RULE23
    wire byte_t rx_crc    = crc8(crc8(`CRC_INIT, cmd1), rx_full); // RULE16
    wire        crc_ok    = (rx_full == cmd_crc);
    wire        is_rdata  = (cmd1 == `CMD_RDATA);
    wire        is_register_read_cmd   = (op_base == 3'(`CMD_REG_READ_BASE >> `CMD_BASE_LO));

    // Register data is read straight across; writes only land after a frame
    wire byte_t reg_rd = (op_addr == `STATUS_ADDR) ? status_byte :
                         (32'(op_addr) < REG_COUNT) ? reg_file[op_addr] : `UNMAPPED_READ;

    wire [2:0]  load_len = is_rdata ? (stat_en ? `PAY_LEN_DATA_STAT : `PAY_LEN_DATA) :
                           is_register_read_cmd ? `PAY_LEN_REG : `PAY_LEN_NONE;
    wire [39:0] load_pay = is_rdata ? (stat_en ? {snap_status, snap_word, 8'h00}
                                               : {snap_word, 16'h0000}) :
                           {reg_rd, 32'h00000000}; // RULE1 RULE13
    wire byte_t first_tx = (load_len != 3'd0) ? load_pay[39:32] : `IDLE_FILL;

    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            bit_cnt <= 3'd0; // RULE17
        else
            bit_cnt <= bit_cnt + 3'd1;
    end

    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            rx_sh <= 8'h00;
        else
            rx_sh <= rx_full;
    end

    // ------------------------------------------------------------------
    // Link side: frame sequencer
    // ------------------------------------------------------------------
    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            phase    <= PH_CMD1; // RULE17
            cmd_crc  <= 8'h00;
            tx_byte  <= `IDLE_FILL; // RULE24
            pay      <= 40'h0;
            pay_left <= 3'd0;
            pay_crc  <= `CRC_INIT;
            crc_pend <= 1'b0;
            busy     <= 1'b1;
        end
        else if (byte_done)
        begin
            case (phase)
                PH_CMD1:
                begin
                    tx_byte <= rx_full; // RULE14
                    busy    <= 1'b1;
                    phase   <= PH_CMD2;
                end
                PH_CMD2:
                begin
                    cmd_crc <= rx_crc;
                    if (crc_en)
                    begin
                        tx_byte <= rx_full; // RULE14
                        phase   <= PH_CRC;
                    end
                    else
                    begin
                        tx_byte  <= first_tx; // RULE15
                        pay      <= load_pay << 8;
                        pay_left <= (load_len != 3'd0) ? load_len - 3'd1 : 3'd0;
                        pay_crc  <= crc8(`CRC_INIT, load_pay[39:32]);
                        crc_pend <= 1'b0;
                        phase    <= PH_PAY;
                    end
                end
                PH_CRC:
                begin
                    tx_byte <= crc_ok ? cmd_crc : ~cmd_crc; // RULE7 RULE9
                    cmd_crc <= {7'h00, crc_ok};
                    phase   <= PH_ZERO;
                end
                PH_ZERO:
                begin
                    if (cmd_crc[0])
                    begin
                        tx_byte  <= first_tx; // RULE15
                        pay      <= load_pay << 8;
                        pay_left <= (load_len != 3'd0) ? load_len - 3'd1 : 3'd0;
                        pay_crc  <= crc8(`CRC_INIT, load_pay[39:32]); // RULE13 RULE25
                        crc_pend <= (load_len != 3'd0); // RULE8
                        phase    <= PH_PAY;
                    end
                    else
                    begin
                        tx_byte <= `IDLE_FILL; // RULE11
                        busy    <= 1'b0;
                        phase   <= PH_CMD1;
                    end
                end
                default:
                begin
                    if (pay_left != 3'd0)
                    begin
                        tx_byte  <= pay[39:32];
                        pay      <= pay << 8;
                        pay_crc  <= crc8(pay_crc, pay[39:32]); // RULE13
                        pay_left <= pay_left - 3'd1;
                    end
                    else if (crc_pend)
                    begin
                        tx_byte  <= pay_crc; // RULE8
                        crc_pend <= 1'b0;
                    end
                    else
                    begin
                        tx_byte <= `IDLE_FILL;
                        busy    <= 1'b0;
                        phase   <= PH_CMD1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Link side: event toggles, cleared only by the core reset
    // ------------------------------------------------------------------
    // Select must not clear these, or an event in flight would be lost
    wire exec_now = byte_done && (((phase == PH_CMD2) && !crc_en)
                    || ((phase == PH_ZERO) && cmd_crc[0])); // RULE15 RULE20
    wire fail_now = byte_done && (phase == PH_CRC) && !crc_ok; // RULE9 RULE10

    always_ff @(negedge sclk_in or posedge link_rst)
    begin
        if (link_rst)
        begin
            exec_tgl <= 1'b0;
            fail_tgl <= 1'b0;
            cmd1     <= 8'h00;
            cmd2     <= 8'h00;
        end
        else
        begin
            exec_tgl <= exec_tgl ^ exec_now;
            fail_tgl <= fail_tgl ^ fail_now;
            if (byte_done && (phase == PH_CMD1))
                cmd1 <= rx_full;
            if (byte_done && (phase == PH_CMD2))
                cmd2 <= rx_full;
        end
    end

    // ------------------------------------------------------------------
    // Link side: shift out on the rising edge
    // ------------------------------------------------------------------
    always_ff @(posedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            sout <= 1'b1;
        else
            sout <= tx_byte[3'd7 - bit_cnt]; // RULE2 RULE23
    end

    // Ready level shows once the response is over
    assign serial_out_ready_pin_out      = busy ? sout : ready_n_in;
    assign serial_out_ready_pin_oe_n_out = cs_sync;

endmodule

/* src/spi_frontend_regs.svh */
// Constants of the serial command front end: opcodes, fields, codes, defaults
`ifndef SPI_FRONTEND_REGS_SVH
`define SPI_FRONTEND_REGS_SVH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define CMD_NOP              8'h00
`define CMD_RESET            8'h06
`define CMD_START            8'h08
`define CMD_STOP             8'h0a
`define CMD_RDATA            8'h12
`define CMD_SYS_OFFSET_CAL   8'h16
`define CMD_GAIN_CAL         8'h17
`define CMD_SELF_OFFSET_CAL  8'h19
`define CMD_LOCK             8'hf2
`define CMD_UNLOCK           8'hf5
`define CMD_REG_READ_BASE    8'h20
`define CMD_REG_WRITE_BASE   8'h40
`define CMD_BASE_HI          7
`define CMD_BASE_LO          5
`define CMD_ADDR_HI          4

// ----------------------------------------------------------------------
// Checksum and fill values
// ----------------------------------------------------------------------
`define CRC_POLY             8'h07
`define CRC_INIT             8'hff
`define IDLE_FILL            8'hff
`define UNMAPPED_READ        8'h00

// ----------------------------------------------------------------------
// Conversion codes
// ----------------------------------------------------------------------
`define CODE_POS_FULL        24'h7fffff
`define CODE_NEG_FULL        24'h800000
`define CODE_ZERO            24'h000000

// ----------------------------------------------------------------------
// Register addresses, fields and reset values
// ----------------------------------------------------------------------
`define STATUS_ADDR          5'h01
`define MODE_CONFIG_THREE_ADDR           5'h05
`define MODE_CONFIG_THREE_CRC_BIT        0
`define MODE_CONFIG_THREE_STAT_BIT       1
`define STATUS_CRCFAIL_MASK  8'h40
`define STATUS_LOCK_MASK     8'h01
`define STATUS_CLEAR_BIT     6
`define REG_DEFAULT          8'h00

// ----------------------------------------------------------------------
// Response lengths in bytes
// ----------------------------------------------------------------------
`define PAY_LEN_DATA         3'd3
`define PAY_LEN_DATA_STAT    3'd4
`define PAY_LEN_REG          3'd1
`define PAY_LEN_NONE         3'd0

`endif

/* src/spi_frontend_pkg.sv */
// Types shared by the serial command front end
package spi_frontend_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [2:0]
    {
        PH_CMD1,
        PH_CMD2,
        PH_CRC,
        PH_ZERO,
        PH_PAY
    } phase_t;

endpackage

/* dv/spi_command_crc_frontend_monitor.sv */
// Checker of the front end's command outputs and pin enable
`timescale 1ns/1ps
module spi_command_crc_frontend_monitor
    import spi_frontend_pkg::*;
(
    input wire logic  mclk_in,
    input wire logic  reset_in,
    input wire logic  cs_n_in,
    input wire logic  serial_out_ready_pin_oe_n_out,
    input wire logic  conv_run_out,
    input wire logic  start_pulse_out,
    input wire logic  stop_pulse_out,
    input wire logic  reset_pulse_out,
    input wire logic  system_offset_cal_cmd_out,
    input wire logic  gain_cal_cmd_out,
    input wire logic  self_offset_cal_cmd_out,
    input wire logic  crc_fail_flag_out,
    input wire logic  locked_out,
    input wire byte_t mode_config_three_out
);
    logic [5:0] cmds;
    assign cmds = {start_pulse_out, stop_pulse_out, reset_pulse_out,
                   system_offset_cal_cmd_out, gain_cal_cmd_out, self_offset_cal_cmd_out};
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    start_run_a: assert property (start_pulse_out |-> ##[0:1] conv_run_out)
        else $error("run level missing after start");
    stop_halt_a: assert property (stop_pulse_out |-> ##[0:1] !conv_run_out)
        else $error("run level stays after stop");
    reset_clear_a: assert property (reset_pulse_out |-> ##[0:2]
        (mode_config_three_out == 8'h00 && !locked_out && !crc_fail_flag_out && !conv_run_out))
        else $error("state kept after reset command");
    one_cmd_a: assert property ($onehot0(cmds))
        else $error("two commands at once");
    pulse_short_a: assert property (|cmds |=> !(|cmds))
        else $error("command pulse too long");
    // Frames are far apart, so no command sits beside a failure
    fail_noexec_a: assert property ($rose(crc_fail_flag_out) |-> !(|cmds) [*4])
        else $error("command beside a failed check");
    // Select passes two flops, hence four samples
    oe_off_a: assert property (cs_n_in [*4] |-> serial_out_ready_pin_oe_n_out)
        else $error("pin driven while deselected");
    oe_on_a: assert property (!cs_n_in [*4] |-> !serial_out_ready_pin_oe_n_out)
        else $error("pin released while selected");
endmodule
bind spi_command_crc_frontend spi_command_crc_frontend_monitor i_spi_command_crc_frontend_monitor (.*);

/* dv/spi_host_model.sv */
// Host controller model of the mode 1 serial link
`timescale 1ns/1ps
module spi_host_model
    import spi_frontend_pkg::*;
(
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    input  wire logic pin_in
);
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // Preset all ones, MSB first
    function automatic byte_t crc(input logic [31:0] d, input int n);
        byte_t c = 8'hff;
        for (int i = 8 * n - 1; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // Clock runs only in a frame; released data shows the inverse
    task automatic frame(input int n, input logic [71:0] tx, output logic [71:0] rx);
        rx = '0;
        cs_n_out = 1'b0;
        #20;
        for (int i = 8 * n - 1; i >= 0; i--)
        begin
            sclk_out = 1'b1;
            sdi_out = tx[i];
            #6;
            sclk_out = 1'b0;
            rx = {rx[70:0], pin_in};
            #6;
        end
        cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule

/* dv/spi_command_crc_frontend_tb.sv */
// Self-checking bench of the serial command front end
`timescale 1ns/1ps
`define CHK(a, e) n_checks++; \
    if ((a) !== (e)) begin miscompares++; $display("Error %0t value mismatch", $time); end
module spi_command_crc_frontend_tb;
    import spi_frontend_pkg::*;
    logic        mclk_in, reset_in, sclk_in, cs_n_in, sdi_in, conv_valid_in, ready_n_in;
    logic        serial_out_ready_pin_out, serial_out_ready_pin_oe_n_out, conv_run_out;
    logic        start_pulse_out, stop_pulse_out, reset_pulse_out, locked_out;
    logic        system_offset_cal_cmd_out, gain_cal_cmd_out, self_offset_cal_cmd_out;
    logic        crc_fail_flag_out;
    logic [25:0] conv_raw_in;
    logic [5:0]  cmds;
    byte_t       status_in, mode_config_three_out, c;
    int          miscompares = 0, n_checks = 0;
    assign cmds = {start_pulse_out, stop_pulse_out, system_offset_cal_cmd_out,
                   gain_cal_cmd_out, self_offset_cal_cmd_out, reset_pulse_out};
    spi_command_crc_frontend i_spi_command_crc_frontend (.*);
    spi_host_model i_spi_host_model (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
                                     .sdi_out(sdi_in), .pin_in(serial_out_ready_pin_out));
    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic conv(input logic [25:0] v);
        conv_raw_in = v;
        conv_valid_in = 1'b1;
        tick(1);
        conv_valid_in = 1'b0;
        tick(4);
    endtask
    // Execution lands a few core cycles after the frame
    task automatic run(input int n, input logic [71:0] tx, ex, input logic [6:0] ec);
        logic [71:0] rx;
        logic [5:0]  seen = '0;
        i_spi_host_model.frame(n, tx, rx);
        `CHK(rx, ex)
        repeat (16)
        begin
            tick(1);
            seen |= cmds;
        end
        `CHK({locked_out, seen}, ec)
    endtask
    task automatic t_cmds();
        byte_t      op[8] = '{8'h00, 8'h08, 8'h0a, 8'h16, 8'h17, 8'h19, 8'hf2, 8'hf5};
        logic [6:0] ec[8] = '{7'h00, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h40, 7'h00};
        foreach (op[i])
            run(2, {op[i], 8'h5a}, {8'hff, op[i]}, ec[i]);
        $display("command table done");
    endtask
    task automatic t_data();
        logic [25:0] raw[5] = '{26'h0900000, 26'h3700000, 26'h3800000, 26'h3ffffff, 26'h0};
        logic [23:0] ex[5] = '{24'h7fffff, 24'h800000, 24'h800000, 24'hffffff, 24'h0};
        foreach (raw[i])
        begin
            conv(raw[i]);
            run(5, 40'h1200000000, {16'hff12, ex[i]}, 7'h00);
        end
        $display("data codes done");
    endtask
    task automatic t_crc();
        run(2, 16'h4503, 16'hff45, 7'h00);
        `CHK(mode_config_three_out, 8'h03)
        conv(26'h0123456);
        c = i_spi_host_model.crc(16'h1200, 2);
        run(9, {16'h1200, c, 48'h0}, {24'hff1200, c, 32'h24123456,
            i_spi_host_model.crc(32'h24123456, 4)}, 7'h00);
        c = i_spi_host_model.crc(16'h2500, 2);
        run(6, {16'h2500, c, 24'h0}, {24'hff2500, c, 8'h03,
            i_spi_host_model.crc(8'h03, 1)}, 7'h00);
        $display("checksum reads done");
    endtask
    task automatic t_bad();
        c = i_spi_host_model.crc(16'h0800, 2);
        run(4, {16'h0800, ~c, 8'h00}, {24'hff0800, ~c}, 7'h00);
        `CHK(crc_fail_flag_out, 1'b1)
        run(3, {16'h0800, c}, 24'hff0800, 7'h00);
        run(4, {16'h0800, c, 8'h00}, {24'hff0800, c}, 7'h20);
        c = i_spi_host_model.crc(16'h0600, 2);
        run(4, {16'h0600, c, 8'h00}, {24'hff0600, c}, 7'h01);
        `CHK({mode_config_three_out, crc_fail_flag_out, conv_run_out}, 10'h0)
        $display("failure and reset done");
    endtask
    task automatic results();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        reset_in = 1'b1;
        conv_valid_in = 1'b0;
        ready_n_in = 1'b1;
        conv_raw_in = '0;
        status_in = 8'h24;
        tick(16);
        reset_in = 1'b0;
        tick(4);
        t_cmds();
        t_data();
        t_crc();
        t_bad();
        results();
    end
endmodule
